// >>> rtl/mcs_pkg.sv
// Package: constants and types for the major cycle state scheduler
package mcs_pkg;
  localparam int NUM_STATES = 8;
  localparam int STATE_W = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MINOR_NS = 200;
  localparam int MINOR_CLKS = (MINOR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MINOR_CNT_W = 5;
  localparam logic [3:0] MINORS_PLAIN = 4'h8;
  localparam logic [3:0] MINORS_STORAGE = 4'h9;
  localparam int GPR_PER_STATE = 8;
  localparam int REGS_PER_STATE = 10;
  localparam int REG_SEL_W = 4;
  localparam logic [3:0] REG_COND = 4'h8;
  localparam logic [3:0] REG_PADDR = 4'h9;
  localparam int DATA_W = 16;
  localparam int ACCT_W = 32;
  localparam logic [7:0] IO_STATE_MASK = 8'h1d;
  localparam logic [2:0] ROLE_COMMS = 3'h0;
  localparam logic [2:0] ROLE_SELECTOR = 3'h2;
  localparam logic [2:0] ROLE_DISC = 3'h3;
  localparam logic [2:0] ROLE_EXEC = 3'h4;

  typedef enum logic [1:0] {
    MCS_IDLE = 2'b00,
    MCS_RUN = 2'b01
  } mcs_phase_type;

  typedef struct packed {
    logic valid;
    logic [STATE_W-1:0] state;
    logic storage;
  } mcs_grant_type;

  typedef struct packed {
    logic wr_en;
    logic [REG_SEL_W-1:0] sel;
    logic [DATA_W-1:0] data;
  } mcs_reg_req_type;
endpackage

// >>> rtl/mcs_context_file.sv
// Per-state register context: eight GPRs, condition and program address
`timescale 1ns/10ps
module mcs_context_file #(
  parameter int NUM = 8,
  parameter int REGS = 10,
  parameter int DW = 16
) (
  input wire logic sys_clk_in,
  input wire logic [2:0] state_in,
  input wire mcs_pkg::mcs_reg_req_type req_in,
  input wire logic access_in,
  output logic [DW-1:0] rd_data_out
);
  logic [DW-1:0] mem_reg [NUM*REGS];
  wire [6:0] addr_idx = 7'(state_in * REGS) + 7'(req_in.sel);
  wire sel_ok = req_in.sel < 4'(REGS);

  // Only the granted state's set is touched
  always_ff @(posedge sys_clk_in) begin
    if (access_in && req_in.wr_en && sel_ok) begin
      mem_reg[addr_idx] <= req_in.data;
    end
    rd_data_out <= sel_ok ? mem_reg[addr_idx] : '0;
  end
endmodule

// >>> rtl/mcs_scheduler.sv
// Major cycle scheduler: rotating grant over eight processor states
`timescale 1ns/10ps
module mcs_scheduler #(
  parameter int NUM = 8,
  parameter int ACCT_W = 32,
  parameter bit ACCT_EN = 1'b1
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] req_in,
  input wire logic [7:0] storage_ref_in,
  input wire logic [7:0] urgent_in,
  input wire logic prio_mode_in,
  input wire logic consec_mode_in,
  input wire mcs_pkg::mcs_reg_req_type reg_req_in,
  input wire logic [2:0] acct_sel_in,
  output mcs_pkg::mcs_grant_type grant_out,
  output logic [7:0] grant_onehot_out,
  output logic cycle_end_out,
  output logic minor_tick_out,
  output logic [3:0] minor_idx_out,
  output logic [15:0] reg_rd_data_out,
  output logic [ACCT_W-1:0] acct_count_out
);
  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [7:0] req_s1_reg, req_s2_reg, urg_s1_reg, urg_s2_reg;
  logic [7:0] sto_s1_reg, sto_s2_reg;
  logic [1:0] mode_s1_reg, mode_s2_reg;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      req_s1_reg <= 8'h00;
      req_s2_reg <= 8'h00;
      urg_s1_reg <= 8'h00;
      urg_s2_reg <= 8'h00;
      sto_s1_reg <= 8'h00;
      sto_s2_reg <= 8'h00;
      mode_s1_reg <= 2'h0;
      mode_s2_reg <= 2'h0;
    end else begin
      req_s1_reg <= req_in;
      req_s2_reg <= req_s1_reg;
      urg_s1_reg <= urgent_in;
      urg_s2_reg <= urg_s1_reg;
      sto_s1_reg <= storage_ref_in;
      sto_s2_reg <= sto_s1_reg;
      mode_s1_reg <= {prio_mode_in, consec_mode_in};
      mode_s2_reg <= mode_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Minor cycle divider
  logic [mcs_pkg::MINOR_CNT_W-1:0] div_reg;
  wire div_wrap = div_reg == mcs_pkg::MINOR_CNT_W'(mcs_pkg::MINOR_CLKS - 1);
  wire [mcs_pkg::MINOR_CNT_W-1:0] div_next = div_wrap ? '0 : div_reg + 1'b1;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) div_reg <= '0;
    else div_reg <= div_next;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Major cycle sequencing
  mcs_pkg::mcs_phase_type phase_reg, phase_next;
  logic [3:0] minor_reg, minor_next;
  logic [3:0] major_len_reg;
  logic [2:0] scan_reg;
  logic [2:0] last_reg;
  logic last_valid_reg;

  // Rotating search: first requester at or after start, ascending with wrap
  function automatic logic [3:0] pick_next(input logic [7:0] mask, input logic [2:0] start);
    logic [3:0] res;
    res = 4'h0;
    for (int k = NUM - 1; k >= 0; k--) begin
      if (mask[3'(start + 3'(k))]) res = {1'b1, 3'(start + 3'(k))};
    end
    return res;
  endfunction

  wire [7:0] req_w = req_s2_reg;
  wire lone_req = $onehot(req_w);
  wire hold_last = last_valid_reg && !(mode_s2_reg[0] && lone_req);
  // Exclude last grantee when others wait
  wire [7:0] excl_mask = (hold_last && (req_w & ~(8'h01 << last_reg)) != 8'h00) ?
                         (req_w & ~(8'h01 << last_reg)) : req_w;
  wire [7:0] urg_mask = excl_mask & urg_s2_reg & mcs_pkg::IO_STATE_MASK;
  wire [3:0] scan_pick = pick_next(excl_mask, scan_reg);
  wire [3:0] urg_pick = pick_next(urg_mask, 3'h0);
  wire use_urg = mode_s2_reg[1] && urg_pick[3];
  wire [3:0] win = use_urg ? urg_pick : scan_pick;
  wire minor_tick_w = div_wrap;
  wire major_end = minor_tick_w && (phase_reg == mcs_pkg::MCS_IDLE ||
                   minor_reg == major_len_reg - 4'h1);
  wire [3:0] len_pick = sto_s2_reg[win[2:0]] ? mcs_pkg::MINORS_STORAGE
                                             : mcs_pkg::MINORS_PLAIN;

  always_comb begin
    phase_next = phase_reg;
    minor_next = minor_reg;
    if (minor_tick_w) begin
      minor_next = major_end ? 4'h0 : minor_reg + 4'h1;
      if (major_end) phase_next = win[3] ? mcs_pkg::MCS_RUN : mcs_pkg::MCS_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_reg <= mcs_pkg::MCS_IDLE;
      minor_reg <= 4'h0;
      major_len_reg <= mcs_pkg::MINORS_PLAIN;
      scan_reg <= 3'h0;
      last_reg <= 3'h0;
      last_valid_reg <= 1'b0;
      grant_out <= '0;
      grant_onehot_out <= 8'h00;
      cycle_end_out <= 1'b0;
      minor_tick_out <= 1'b0;
      minor_idx_out <= 4'h0;
    end else begin
      phase_reg <= phase_next;
      minor_reg <= minor_next;
      cycle_end_out <= major_end;
      minor_tick_out <= minor_tick_w;
      minor_idx_out <= minor_next;
      if (major_end) begin
        last_valid_reg <= win[3];
        last_reg <= win[2:0];
        major_len_reg <= win[3] ? len_pick : mcs_pkg::MINORS_PLAIN;
        if (win[3] && !use_urg) scan_reg <= win[2:0] + 3'h1;
        grant_out.valid <= win[3];
        grant_out.state <= win[2:0];
        grant_out.storage <= win[3] & sto_s2_reg[win[2:0]];
        grant_onehot_out <= win[3] ? (8'h01 << win[2:0]) : 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Context registers and job accounting
  wire ctx_access = grant_out.valid;

  mcs_context_file #(
    .NUM(NUM),
    .REGS(mcs_pkg::REGS_PER_STATE),
    .DW(mcs_pkg::DATA_W)
  ) u_ctx (
    .sys_clk_in(sys_clk_in),
    .state_in(grant_out.state),
    .req_in(reg_req_in),
    .access_in(ctx_access),
    .rd_data_out(reg_rd_data_out)
  );

  logic [ACCT_W-1:0] acct_reg [NUM];
  genvar g;
  generate
    for (g = 0; g < NUM; g++) begin : g_acct
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) acct_reg[g] <= '0;
        else if (ACCT_EN && major_end && win[3] && win[2:0] == 3'(g))
          acct_reg[g] <= acct_reg[g] + 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) acct_count_out <= '0;
    else acct_count_out <= acct_reg[acct_sel_in];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_end_granted;
    major_end && win[3];
  endsequence

  sequence s_end_idle;
    major_end && !win[3];
  endsequence

  one_grant_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $onehot0(grant_onehot_out) && (grant_out.valid == (grant_onehot_out != 8'h00)))
    else $error("grant not exclusive");
  grant_req_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_end_granted |=> grant_onehot_out[grant_out.state])
    else $error("granted state not selected");
  scan_order_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (major_end && req_w == 8'hff && !use_urg && last_valid_reg && last_reg != scan_reg) |->
      win[2:0] == scan_reg)
    else $error("scan order broken");
  wrap_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_end_granted and (!use_urg && win[2:0] == 3'h7)) |=> scan_reg == 3'h0)
    else $error("scan did not wrap");
  skip_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_end_granted |-> req_w[win[2:0]])
    else $error("idle state granted");
  no_repeat_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_end_granted and (last_valid_reg && !mode_s2_reg[0] &&
     (req_w & ~(8'h01 << last_reg)) != 8'h00)) |-> win[2:0] != last_reg)
    else $error("back to back grant");
  consec_grant_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_end_granted and (mode_s2_reg[0] && lone_req && last_valid_reg &&
     req_w[last_reg])) |-> win[2:0] == last_reg)
    else $error("lone requester not repeated");
  grant_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !$past(major_end) |-> $stable(grant_out))
    else $error("grant moved mid cycle");
  end_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    cycle_end_out |=> !cycle_end_out)
    else $error("cycle end too long");
  tick_period_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    minor_tick_w |-> ##20 minor_tick_w)
    else $error("minor period wrong");
  storage_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_end_granted and sto_s2_reg[win[2:0]]) |=> major_len_reg == 4'h9)
    else $error("storage cycle not long");
  minor_range_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    minor_reg < major_len_reg)
    else $error("minor index overrun");
  acct_step_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_end_granted |=>
      (!ACCT_EN || acct_reg[grant_out.state] == $past(acct_reg[win[2:0]]) + ACCT_W'(1)))
    else $error("job count not advanced");
  idle_phase_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_end_idle |=> phase_reg == mcs_pkg::MCS_IDLE && grant_onehot_out == 8'h00)
    else $error("idle cycle not idle");
  prio_io_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (major_end && use_urg) |-> mcs_pkg::IO_STATE_MASK[win[2:0]])
    else $error("priority to non io state");
  major_len_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(phase_reg == mcs_pkg::MCS_RUN) |-> major_len_reg inside {4'h8, 4'h9})
    else $error("bad major length");
  no_req_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (major_end && req_w == 8'h00) |=> !grant_out.valid)
    else $error("grant without request");
endmodule

// >>> tb/mcs_req_model.sv
// Model of the eight processor states asking for major cycles
`timescale 1ns/10ps
module mcs_req_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] pend_in,
  input wire logic [7:0] sref_in,
  input wire logic [7:0] urg_in,
  output logic [7:0] req_out,
  output logic [7:0] sref_out,
  output logic [7:0] urg_out
);
  logic [7:0] junk = 8'h5a;
  initial {req_out, sref_out, urg_out} = 24'h00_0000;
  // Idle states show churning storage bits
  always @(negedge sys_clk_in) begin
    junk <= ~junk;
    req_out <= pend_in;
    sref_out <= (sref_in & pend_in) | (junk & ~pend_in);
    urg_out <= urg_in;
  end
endmodule

// >>> tb/mcs_scheduler_tb_top.sv
// Self-checking bench for the major cycle scheduler
`timescale 1ns/10ps
module mcs_scheduler_tb_top;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] pend = 8'h00, sref = 8'h00, urg = 8'h00;
  logic [7:0] req, sref_w, urg_w, onehot;
  logic prio = 1'b0, consec = 1'b0, cend;
  logic [2:0] asel = 3'h0;
  logic [15:0] rdata;
  logic [31:0] acnt;
  mcs_pkg::mcs_reg_req_type rreq = '0;
  mcs_pkg::mcs_grant_type gnt;
  int n_mismatch = 0, comparisons = 0, seed = 66, cyc = 0, len = 0;
  int ptr = 0, last = -1, exp_g = -1, exp_len = 0, urg_hit = 0;
  logic [31:0] cnt [8] = '{default: 32'h0000_0000};
  logic [9:0] known [8] = '{default: 10'h000};
  logic [15:0] ctx [8][10];

  mcs_req_model model (
    .sys_clk_in(sys_clk_in),
    .pend_in(pend),
    .sref_in(sref),
    .urg_in(urg),
    .req_out(req),
    .sref_out(sref_w),
    .urg_out(urg_w)
  );
  mcs_scheduler #(.NUM(8), .ACCT_W(32), .ACCT_EN(1'b1)) dut (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .req_in(req),
    .storage_ref_in(sref_w),
    .urgent_in(urg_w),
    .prio_mode_in(prio),
    .consec_mode_in(consec),
    .reg_req_in(rreq),
    .acct_sel_in(asel),
    .grant_out(gnt),
    .grant_onehot_out(onehot),
    .cycle_end_out(cend),
    .minor_tick_out(),
    .minor_idx_out(),
    .reg_rd_data_out(rdata),
    .acct_count_out(acnt)
  );

  ////////////////////////////////////////////////////////////
  initial forever #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    len <= cend ? 1 : len + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end

  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Expected next grantee, -1 for none
  function automatic int pick(logic [7:0] p, u, logic pm);
    logic [7:0] c, v;
    int i, g;
    g = -1;
    urg_hit = 0;
    c = p;
    if ($countones(p) > 1 && last >= 0) c[last] = 1'b0;
    v = u & c & mcs_pkg::IO_STATE_MASK;
    if (pm && v != 8'h00) begin
      urg_hit = 1;
      for (i = 7; i >= 0; i--) if (v[i]) g = i;
      return g;
    end
    for (i = 7; i >= 0; i--) if (c[(ptr + i) % 8]) g = (ptr + i) % 8;
    return g;
  endfunction

  task automatic step(input logic [7:0] p, u, input logic pm, cm);
    int i, g, r, r2;
    logic [15:0] d;
    i = 0;
    while (cend !== 1'b1 && i < 400) begin
      @(negedge sys_clk_in);
      i++;
    end
    chk(gnt.valid === (exp_g >= 0), "grant valid");
    chk(onehot === (exp_g < 0 ? 8'h00 : 8'h01 << exp_g), "one-hot grant");
    if (exp_g >= 0) chk(gnt.state === exp_g[2:0], "grant order");
    if (exp_g >= 0) chk(gnt.storage === sref[exp_g], "storage flag");
    if (exp_len > 0) chk(len == exp_len, "major cycle length");
    g = exp_g;
    if (g >= 0) begin
      cnt[g]++;
      last = g;
    end else begin
      last = -1;
    end
    exp_len = g < 0 ? 20 : (sref[g] ? 180 : 160);
    pend <= p;
    urg <= u;
    prio <= pm;
    consec <= cm;
    sref <= 8'($random(seed));
    asel <= 3'($random(seed));
    exp_g = pick(p, u, pm);
    if (exp_g >= 0 && urg_hit == 0) ptr = (exp_g + 1) % 8;
    r = {$random(seed)} % 10;
    r2 = {$random(seed)} % 16;
    d = 16'($random(seed));
    if (g >= 0) rreq <= '{1'b1, 4'(r), d};
    @(negedge sys_clk_in);
    rreq <= '{1'b0, 4'(r2), 16'h0000};
    repeat (2) @(negedge sys_clk_in);
    if (g >= 0) begin
      ctx[g][r] = d;
      known[g][r] = 1'b1;
      if (r2 > 9 || known[g][r2]) chk(rdata === (r2 > 9 ? 16'h0000 : ctx[g][r2]), "context");
    end
    if (asel != g) chk(acnt === cnt[asel], "job count");
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    int k;
    logic [7:0] p, u;
    logic pm, cm;
    repeat (12) @(negedge sys_clk_in);
    rst_n_in <= 1'b1;
    repeat (2) step(8'h00, 8'h00, 1'b0, 1'b0);
    for (k = 0; k < 10; k++) step(8'hff, 8'h00, 1'b0, 1'b0);
    for (k = 0; k < 6; k++) step(8'hfd, 8'h00, 1'b0, 1'b0);
    repeat (3) step(8'h20, 8'h00, 1'b0, 1'b1);
    step(8'h60, 8'h00, 1'b0, 1'b1);
    step(8'hff, 8'h08, 1'b1, 1'b0);
    step(8'hff, 8'he2, 1'b1, 1'b0);
    for (k = 0; k < 40; k++) begin
      p = 8'($random(seed));
      cm = 1'($random(seed));
      pm = 1'($random(seed));
      if (!cm && $countones(p) < 2) p = 8'hff;
      u = 8'($random(seed));
      if (last >= 0) u[last] = 1'b0;
      step(p, u, pm, cm);
    end
    step(8'h00, 8'h00, 1'b0, 1'b0);
    end_sim();
  end
endmodule
